/* design/ctmc_pin_sync.sv */
// Three-stage pin synchroniser for transmit data and receiver decision
`default_nettype none
module ctmc_pin_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic tx_data_in,
  input  wire logic bus_dom_in,
  ctmc_sync_if.src  sync
);
  logic [2:0] tx_sh_r;
  logic [2:0] tx_sh_nxt;
  logic [2:0] bd_sh_r;
  logic [2:0] bd_sh_nxt;
  logic       tx_r;
  logic       tx_nxt;
  logic       bd_r;
  logic       bd_nxt;

  // Shift in; a level counts only once stages two and three agree
  always_comb begin
    tx_sh_nxt = {tx_sh_r[1:0], tx_data_in};
    bd_sh_nxt = {bd_sh_r[1:0], bus_dom_in};
    tx_nxt    = (tx_sh_r[1] == tx_sh_r[2]) ? tx_sh_r[2] : tx_r;
    bd_nxt    = (bd_sh_r[1] == bd_sh_r[2]) ? bd_sh_r[2] : bd_r;
  end

  // Idle levels: transmit recessive, bus recessive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_sh_r <= 3'h7;
      bd_sh_r <= 3'h0;
      tx_r    <= 1'h1;
      bd_r    <= 1'h0;
    end else begin
      tx_sh_r <= tx_sh_nxt;
      bd_sh_r <= bd_sh_nxt;
      tx_r    <= tx_nxt;
      bd_r    <= bd_nxt;
    end
  end

  assign sync.tx_data = tx_r;
  assign sync.bus_dom = bd_r;
endmodule
`default_nettype wire

/* design/ctmc_pkg.sv */
// Package of constants and types for the CAN transceiver mode control block
`default_nettype none
package ctmc_pkg;
  // Transceiver mode field encodings
  typedef enum logic [1:0] {
    CTMC_TRX_OFF     = 2'h0,
    CTMC_TRX_WAKE    = 2'h1,
    CTMC_TRX_RXONLY  = 2'h2,
    CTMC_TRX_NORMAL  = 2'h3
  } ctmc_trx_mode_t;

  // Chip operating modes
  typedef enum logic [2:0] {
    CTMC_CHIP_NORMAL   = 3'h0,
    CTMC_CHIP_STOP     = 3'h1,
    CTMC_CHIP_SLEEP    = 3'h2,
    CTMC_CHIP_RESTART  = 3'h3,
    CTMC_CHIP_FAILSAFE = 3'h4
  } ctmc_chip_mode_t;

  // Clock and timing
  localparam int CLK_HZ            = 25000000;
  localparam int EN_DELAY_NS       = 8000;    // Driver enabling delay, ns
  localparam int EN_DELAY_CYC      = (EN_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WAKE_FILT_NS      = 1000;    // Least time for each dominant or recessive wake phase, ns
  localparam int WAKE_FILT_CYC     = (WAKE_FILT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WAKE_PHASES       = 4;       // Dominant, recessive, dominant, recessive
  localparam int CNT_W             = 10;
  localparam logic [CNT_W-1:0] EN_DELAY_CNT  = CNT_W'(EN_DELAY_CYC);
  localparam logic [CNT_W-1:0] WAKE_FILT_CNT = CNT_W'(WAKE_FILT_CYC);
  localparam logic [2:0]       WAKE_PH_CNT   = 3'(WAKE_PHASES - 1);
endpackage
`default_nettype wire

/* design/ctmc_sync_if.sv */
// Interface carrying the synchronised pin levels to the mode controller
`default_nettype none
interface ctmc_sync_if;
  logic tx_data;   // Filtered transmit data, 1 = recessive
  logic bus_dom;   // Filtered receiver decision, 1 = dominant
  modport src (output tx_data, output bus_dom);
  modport dst (input tx_data, input bus_dom);
endinterface
`default_nettype wire

/* design/ctmc_top.sv */
// CAN transceiver mode control and digital pin behaviour
`default_nettype none

module ctmc_top
  import ctmc_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire ctmc_pkg::ctmc_chip_mode_t chip_mode,
  input  wire logic                      mode_req_valid,
  input  wire ctmc_pkg::ctmc_trx_mode_t  mode_req,
  input  wire logic                      tx_data_in,
  input  wire logic                      bus_dom_in,
  output logic                           rx_data_out,
  output logic                           drv_dominant,
  output logic                           drv_enable,
  output logic                           rx_enable,
  output logic                           drv_ready,
  output ctmc_pkg::ctmc_trx_mode_t       trx_mode,
  output logic                           bus_wake_pulse,
  output logic                           bus_woken
);
  import ctmc_pkg::*;

  typedef enum logic [1:0] {CTMC_WK_IDLE, CTMC_WK_DOM, CTMC_WK_REC} ctmc_wk_state_t;

  ctmc_sync_if sync ();

  ctmc_trx_mode_t mode_r;
  ctmc_trx_mode_t mode_nxt;
  logic [CNT_W-1:0] en_cnt_r;
  logic [CNT_W-1:0] en_cnt_nxt;
  logic             armed_r;
  logic             armed_nxt;
  logic             dom_r;
  logic             dom_nxt;
  logic             woken_r;
  logic             woken_nxt;
  logic             wpulse_r;
  logic             wpulse_nxt;
  logic             rxo_r;
  logic             rxo_nxt;
  ctmc_wk_state_t   wk_r;
  ctmc_wk_state_t   wk_nxt;
  logic [CNT_W-1:0] wk_cnt_r;
  logic [CNT_W-1:0] wk_cnt_nxt;
  logic [2:0]       wk_ph_r;
  logic [2:0]       wk_ph_nxt;
  logic             chip_lowpow_r;
  logic             chip_fs_r;
  logic             req_ok;
  logic             mode_chg;
  logic             wk_done;

  // Synchronise the asynchronous pin levels
  ctmc_pin_sync u_sync (
    .clk        (clk),
    .resetn     (resetn),
    .tx_data_in (tx_data_in),
    .bus_dom_in (bus_dom_in),
    .sync       (sync.src)
  );

  // Permission of a requested mode in the current chip mode
  always_comb begin
    unique case (mode_req)
      CTMC_TRX_OFF:    req_ok = 1'b1;
      CTMC_TRX_NORMAL: req_ok = (chip_mode == CTMC_CHIP_NORMAL);
      CTMC_TRX_RXONLY: req_ok = (chip_mode == CTMC_CHIP_NORMAL) ||
                                (chip_mode == CTMC_CHIP_STOP);
      // Wake Capable anywhere but fail-safe, where it is entered on its own
      CTMC_TRX_WAKE:   req_ok = (chip_mode != CTMC_CHIP_FAILSAFE);
    endcase
  end

  assign mode_chg = mode_req_valid && req_ok && (mode_req != mode_r);

  // Mode, enabling delay and transmit gating
  always_comb begin
    mode_nxt   = mode_r;
    en_cnt_nxt = en_cnt_r;
    armed_nxt  = armed_r;
    dom_nxt    = 1'b0;
    if (mode_chg) begin
      mode_nxt = mode_req;
    end else if (chip_mode == CTMC_CHIP_FAILSAFE && !chip_fs_r) begin
      // forced only on entry, so a later Off request still holds
      mode_nxt = CTMC_TRX_WAKE;
    end
    if (mode_nxt == CTMC_TRX_NORMAL && mode_r != CTMC_TRX_NORMAL) begin
      en_cnt_nxt = EN_DELAY_CNT;
      armed_nxt  = 1'b0;
    end else if (mode_r == CTMC_TRX_NORMAL) begin
      if (en_cnt_r != '0) begin
        en_cnt_nxt = en_cnt_r - 1'b1;
      end
      // arm only on a recessive level after the delay
      if (en_cnt_r == '0 && sync.tx_data) begin
        armed_nxt = 1'b1;
      end
      // drive follows transmit input once armed
      dom_nxt = (mode_nxt == CTMC_TRX_NORMAL) && armed_nxt && !sync.tx_data &&
                (en_cnt_r == '0);
    end
  end

  // Wake pattern: dominant, recessive, dominant, recessive phases of filter length
  assign wk_done = (wk_r != CTMC_WK_IDLE) && (wk_cnt_r == '0) && (wk_ph_r == WAKE_PH_CNT);

  always_comb begin
    wk_nxt     = wk_r;
    wk_cnt_nxt = (wk_cnt_r != '0) ? wk_cnt_r - 1'b1 : wk_cnt_r;
    wk_ph_nxt  = wk_ph_r;
    woken_nxt  = woken_r;
    wpulse_nxt = 1'b0;
    // detector runs only when armed in Wake Capable
    if (mode_r != CTMC_TRX_WAKE || woken_r || mode_chg) begin
      wk_nxt     = CTMC_WK_IDLE;
      wk_cnt_nxt = '0;
      wk_ph_nxt  = '0;
    end else begin
      unique case (wk_r)
        CTMC_WK_IDLE: if (sync.bus_dom) begin
          wk_nxt     = CTMC_WK_DOM;
          wk_cnt_nxt = WAKE_FILT_CNT;
        end
        CTMC_WK_DOM: if (!sync.bus_dom) begin
          // Short dominant phase restarts the search
          wk_nxt     = (wk_cnt_r == '0) ? CTMC_WK_REC : CTMC_WK_IDLE;
          wk_ph_nxt  = (wk_cnt_r == '0) ? wk_ph_r + 3'h1 : 3'h0;
          wk_cnt_nxt = WAKE_FILT_CNT;
        end
        CTMC_WK_REC: if (wk_done) begin
          woken_nxt  = 1'b1;
          wpulse_nxt = 1'b1;
        end else if (sync.bus_dom) begin
          wk_nxt     = (wk_cnt_r == '0) ? CTMC_WK_DOM : CTMC_WK_IDLE;
          wk_ph_nxt  = (wk_cnt_r == '0) ? wk_ph_r + 3'h1 : 3'h0;
          wk_cnt_nxt = WAKE_FILT_CNT;
        end
      endcase
    end
    // woken state cleared by a mode change or rearm
    if (mode_chg) begin
      woken_nxt = 1'b0;
    end
    if (mode_r == CTMC_TRX_WAKE && woken_r && !mode_chg &&
        (chip_mode == CTMC_CHIP_STOP || chip_mode == CTMC_CHIP_SLEEP ||
         chip_mode == CTMC_CHIP_FAILSAFE) && !chip_lowpow_r) begin
      woken_nxt = 1'b0;  // Rearm on entry to a low-power chip mode
    end
    if (woken_nxt && mode_nxt == CTMC_TRX_WAKE) begin
      rxo_nxt = 1'b0;
    end else if (mode_r == CTMC_TRX_NORMAL || mode_r == CTMC_TRX_RXONLY) begin
      rxo_nxt = !sync.bus_dom;
    end else begin
      rxo_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r        <= CTMC_TRX_OFF;
      en_cnt_r      <= '0;
      armed_r       <= 1'b0;
      dom_r         <= 1'b0;
      woken_r       <= 1'b0;
      wpulse_r      <= 1'b0;
      rxo_r         <= 1'b1;
      wk_r          <= CTMC_WK_IDLE;
      wk_cnt_r      <= '0;
      wk_ph_r       <= '0;
      chip_lowpow_r <= 1'b0;
      chip_fs_r     <= 1'b0;
    end else begin
      mode_r        <= mode_nxt;
      en_cnt_r      <= en_cnt_nxt;
      armed_r       <= armed_nxt;
      dom_r         <= dom_nxt;
      woken_r       <= woken_nxt;
      wpulse_r      <= wpulse_nxt;
      rxo_r         <= rxo_nxt;
      wk_r          <= wk_nxt;
      wk_cnt_r      <= wk_cnt_nxt;
      wk_ph_r       <= wk_ph_nxt;
      chip_fs_r     <= (chip_mode == CTMC_CHIP_FAILSAFE);
      chip_lowpow_r <= (chip_mode == CTMC_CHIP_STOP) || (chip_mode == CTMC_CHIP_SLEEP) ||
                       (chip_mode == CTMC_CHIP_FAILSAFE);
    end
  end

  // single-register path keeps 2 Mbaud bits at 12.5 clocks each
  assign drv_dominant   = dom_r;
  assign drv_enable     = (mode_r == CTMC_TRX_NORMAL);
  assign rx_enable      = (mode_r == CTMC_TRX_NORMAL) || (mode_r == CTMC_TRX_RXONLY);
  assign drv_ready      = (mode_r == CTMC_TRX_NORMAL) && (en_cnt_r == '0);
  assign trx_mode       = mode_r;
  assign bus_wake_pulse = wpulse_r;
  assign bus_woken      = woken_r;
  assign rx_data_out    = rxo_r;

  AST_NO_DOM_OFF: assert property (@(posedge clk) disable iff (!resetn)
    (mode_r != CTMC_TRX_NORMAL) |=> !drv_dominant)
    else $error("dominant driven outside Normal mode");
  // no dominant while the delay runs
  AST_EN_DELAY: assert property (@(posedge clk) disable iff (!resetn)
    (drv_enable && !drv_ready) |-> !drv_dominant)
    else $error("dominant during enabling delay");
  AST_RESET_OFF: assert property (@(posedge clk)
    $rose(resetn) |-> trx_mode == CTMC_TRX_OFF)
    else $error("mode not Off after reset");
  AST_OFF_NO_WAKE: assert property (@(posedge clk) disable iff (!resetn)
    (trx_mode == CTMC_TRX_OFF) |-> !bus_wake_pulse && !bus_woken)
    else $error("wake recorded in Off mode");
  AST_REFUSE: assert property (@(posedge clk) disable iff (!resetn)
    (mode_req_valid && mode_req == CTMC_TRX_NORMAL && chip_mode != CTMC_CHIP_NORMAL &&
     chip_mode != CTMC_CHIP_FAILSAFE) |=> trx_mode == $past(trx_mode))
    else $error("illegal mode request accepted");
  AST_FOLLOW: assert property (@(posedge clk) disable iff (!resetn)
    (drv_ready && armed_r && $past(drv_ready) && sync.tx_data && !mode_req_valid) |=>
    !drv_dominant)
    else $error("recessive input drove dominant");
  // the wake pulse comes with rx low in Wake Capable
  AST_WOKEN_RX: assert property (@(posedge clk) disable iff (!resetn)
    bus_wake_pulse |-> trx_mode == CTMC_TRX_WAKE && !rx_data_out)
    else $error("wake not shown on receive output");
  AST_RX_PASS: assert property (@(posedge clk) disable iff (!resetn)
    (rx_enable && $past(rx_enable)) |-> rx_data_out == !$past(sync.bus_dom))
    else $error("receive output does not follow bus");
  // woken keeps receive low until a mode change or a rearm clears it
  AST_WOKEN_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    (bus_woken && trx_mode == CTMC_TRX_WAKE) |-> !rx_data_out)
    else $error("receive output released while woken");
endmodule
`default_nettype wire

/* test/ctmc_host_model.sv */
// Host CAN protocol controller model that drives the transmit pin
`default_nettype none
module ctmc_host_model (
  input  wire logic clk,
  input  wire logic drv_ready,
  input  wire logic bit_val,
  input  wire logic early_low,
  output var  logic tx_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level chosen at the rising edge, so the bench's falling-edge writes never race it
  logic want_r = 1'b1;
  // Recessive from time zero so the pin never floats
  initial tx_data_in = 1'b1;
  // recessive until ready
  // An early low only when the bench asks for the misbehaviour
  always @(posedge clk) begin
    want_r <= early_low ? 1'b0 : (drv_ready ? bit_val : 1'b1);
  end
  // Pin changes at the falling edge
  always @(negedge clk) begin
    tx_data_in <= want_r;
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the CAN transceiver mode control block
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin \
  miscompares++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
  import ctmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk = 1'b0;
  logic            resetn = 1'b0;
  logic            req_v = 1'b0;
  logic            bus_dom = 1'b0;
  logic            bit_val = 1'b1;
  logic            early = 1'b0;
  ctmc_chip_mode_t chip = CTMC_CHIP_NORMAL;
  ctmc_trx_mode_t  req = CTMC_TRX_OFF;
  ctmc_trx_mode_t  mode;
  logic            tx, rx, dom, den, ren, rdy, wpulse, woken;
  int              miscompares = 0;
  int              check_count = 0;
  int              n;
  int              np;

  // Free-running 25 MHz clock
  always #20 clk = ~clk;

  ctmc_host_model host (.clk(clk), .drv_ready(rdy), .bit_val(bit_val),
    .early_low(early), .tx_data_in(tx));

  ctmc_top uut (.clk(clk), .resetn(resetn), .chip_mode(chip), .mode_req_valid(req_v),
    .mode_req(req), .tx_data_in(tx), .bus_dom_in(bus_dom), .rx_data_out(rx),
    .drv_dominant(dom), .drv_enable(den), .rx_enable(ren), .drv_ready(rdy),
    .trx_mode(mode), .bus_wake_pulse(wpulse), .bus_woken(woken));

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // One-cycle command pulse, then one cycle for the mode field to settle
  task automatic ask(input ctmc_chip_mode_t c, input ctmc_trx_mode_t m);
    chip = c;
    req = m;
    req_v = 1'b1;
    cyc(1);
    req_v = 1'b0;
    cyc(1);
  endtask

  // Dominant, recessive, dominant, recessive, each past the filter time; counts pulses
  task automatic wake_pat(output int pulses);
    pulses = 0;
    for (int i = 0; i < 5; i++) begin
      bus_dom = (i % 2 == 0) && (i < 4);
      repeat ((i < 4) ? WAKE_FILT_CYC + 5 : 8) begin
        cyc(1);
        // An unknown pulse level counts as a pulse
        pulses += int'(wpulse !== 1'b0);
      end
    end
  endtask

  // Random bits at 12 cycles each, a little faster than 2 Mbaud, bus looped back
  task automatic stream(input int k, input logic drive);
    logic b;
    for (int i = 0; i < k; i++) begin
      b = 1'($urandom % 2);
      bit_val = b;
      bus_dom = ~b;
      cyc(9);
      `CHK(dom, drive ? ~b : 1'b0, "driver level")
      `CHK(rx, b, "receive level")
      cyc(3);
    end
    bit_val = 1'b1;
    bus_dom = 1'b0;
    cyc(8);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hd0034da2));
    cyc(5);
    resetn = 1'b1;
    cyc(1);
    `CHK(mode, CTMC_TRX_OFF, "mode after reset")
    `CHK(rx, 1'b1, "receive after reset")
    $display("test reset done");
    // Off ignores a full wake pattern and never drives
    wake_pat(np);
    `CHK(np, 0, "wake pulse in off")
    `CHK(woken, 1'b0, "wake seen in off")
    `CHK(den, 1'b0, "driver on in off")
    $display("test off done");
    // Requests not allowed in the chip mode leave the mode alone
    ask(CTMC_CHIP_STOP, CTMC_TRX_NORMAL);
    `CHK(mode, CTMC_TRX_OFF, "normal taken in stop")
    ask(CTMC_CHIP_SLEEP, CTMC_TRX_RXONLY);
    `CHK(mode, CTMC_TRX_OFF, "rx only taken in sleep")
    $display("test refusal done");
    // Receive only in Stop: receiver follows, driver stays off
    ask(CTMC_CHIP_STOP, CTMC_TRX_RXONLY);
    `CHK(mode, CTMC_TRX_RXONLY, "rx only mode")
    `CHK(ren, 1'b1, "receiver enable")
    `CHK(den, 1'b0, "driver enable")
    stream(6, 1'b0);
    $display("test rx only done");
    // Normal entered with the host already pulling low
    early = 1'b1;
    ask(CTMC_CHIP_NORMAL, CTMC_TRX_NORMAL);
    `CHK(mode, CTMC_TRX_NORMAL, "normal mode")
    for (n = 0; n < 400 && rdy !== 1'b1; n++) begin
      `CHK(dom, 1'b0, "dominant during delay")
      cyc(1);
    end
    if (n >= 400) begin
      miscompares++;
      give_verdict();
    end
    // Ready comes EN_DELAY_CYC edges after the mode edge; the loop starts one edge late
    `CHK(n == EN_DELAY_CYC - 1, 1'b1, "delay length")
    cyc(10);
    `CHK(dom, 1'b0, "early low sent")
    early = 1'b0;
    cyc(8);
    bit_val = 1'b0;
    cyc(8);
    `CHK(dom, 1'b1, "next low not sent")
    stream(24, 1'b1);
    $display("test normal done");
    // Wake capable in Stop, woken state held until mode change
    ask(CTMC_CHIP_STOP, CTMC_TRX_WAKE);
    `CHK(rx, 1'b1, "receive before wake")
    wake_pat(np);
    `CHK(np, 1, "wake pulse count")
    `CHK(woken, 1'b1, "wake not seen")
    `CHK(rx, 1'b0, "receive after wake")
    `CHK(mode, CTMC_TRX_WAKE, "mode after wake")
    ask(CTMC_CHIP_STOP, CTMC_TRX_OFF);
    `CHK(rx, 1'b1, "receive after leaving wake")
    `CHK(mode, CTMC_TRX_OFF, "off in stop")
    $display("test wake done");
    // Fail-safe enters Wake Capable by itself, Normal stays refused, Off still holds
    ask(CTMC_CHIP_FAILSAFE, CTMC_TRX_NORMAL);
    `CHK(mode, CTMC_TRX_WAKE, "normal taken in fail-safe")
    ask(CTMC_CHIP_FAILSAFE, CTMC_TRX_OFF);
    cyc(4);
    `CHK(mode, CTMC_TRX_OFF, "off in fail-safe")
    ask(CTMC_CHIP_RESTART, CTMC_TRX_RXONLY);
    `CHK(mode, CTMC_TRX_OFF, "rx only taken in restart")
    $display("test fail-safe done");
    give_verdict();
  end
endmodule
`default_nettype wire
